// >>> pkg/asr_map.svh
// Timing constants and bus widths for the asynchronous SRAM host
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH

// Clock period of core_clk in ns
`define ASR_CLK_NS      100
// Read access time from the last starting event, in ns
`define ASR_T_ACC_NS    120
// Write enable low pulse width, in ns (also covers data setup)
`define ASR_T_WP_NS     100
// Least access time rounds up to whole cycles
`define ASR_ACC_CYC     ((`ASR_T_ACC_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
// Least write pulse rounds up to whole cycles
`define ASR_WP_CYC      ((`ASR_T_WP_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
// Address setup cycles ahead of the write enable falling edge
`define ASR_AS_CYC      1
// Data hold cycles after the write enable rising edge
`define ASR_DH_CYC      1
// Flip-flops in the read data synchroniser
`define ASR_SYNC_CYC    2
// Width of the cycle timer
`define ASR_TMR_W       8
// Address and data widths of the SRAM bus
`define ASR_ADDR_W      17
`define ASR_DATA_W      16

`endif

// >>> pkg/asr_pkg.sv
// Types shared by the asynchronous SRAM host modules
`include "asr_map.svh"
package asr_pkg;

  // Bus sequencer states
  typedef enum logic [2:0]
  {
    ASR_IDLE,
    ASR_W_SETUP,
    ASR_W_PULSE,
    ASR_W_HOLD,
    ASR_R_WAIT
  } asr_fsm_t;

  // Complete register state of the bus sequencer
  typedef struct packed
  {
    asr_fsm_t                 fsm;       // Sequencer state
    logic [`ASR_ADDR_W-1:0]   addr;      // Address pins
    logic [`ASR_DATA_W-1:0]   dq_out;    // Write data pins
    logic                     dq_oe;     // Host drives data pins
    logic                     sel_lo;    // Low-active chip select
    logic                     sel_hi;    // High-active chip select
    logic                     oe_n;      // Output enable
    logic                     we_n;      // Write enable
    logic                     ube_n;     // Upper byte enable
    logic                     lbe_n;     // Lower byte enable
    logic                     ready;     // Request port can accept
    logic                     rd_valid;  // Read data pulse
    logic [`ASR_DATA_W-1:0]   rd_data;   // Captured read word
    logic                     wr_done;   // Write finished pulse
    logic [`ASR_DATA_W-1:0]   dq_s1;     // Data synchroniser stage one
    logic [`ASR_DATA_W-1:0]   dq_s2;     // Data synchroniser stage two
  } asr_state_t;

  // Cycle timer state
  typedef struct packed
  {
    logic [`ASR_TMR_W-1:0]    cnt;       // Remaining cycles
  } asr_tmr_state_t;

endpackage : asr_pkg

// >>> pkg/asr_tmr_if.sv
// Carrier between the bus sequencer and its cycle timer
`timescale 1ns/1ns
`include "asr_map.svh"
interface asr_tmr_if;
  logic                    load;      // Start a new interval
  logic [`ASR_TMR_W-1:0]   load_val;  // Interval length minus one
  logic                    done;      // Interval has run out

  // Sequencer side
  modport ctl (output load, output load_val, input done);
  // Timer side
  modport tmr (input load, input load_val, output done);
endinterface : asr_tmr_if

// >>> design/asr_timer.sv
// Down counter that times the phases of each SRAM bus cycle
`timescale 1ns/1ns
`include "asr_map.svh"
module asr_timer
(
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  asr_tmr_if.tmr     tmr
);

  asr_pkg::asr_tmr_state_t st_q;  // Registered timer state
  asr_pkg::asr_tmr_state_t st_d;  // Next timer state

  // Load on request, otherwise count down to zero and stay
  always_comb
  begin
    st_d = st_q;
    if (tmr.load)
    begin
      st_d.cnt = tmr.load_val;
    end
    else if (st_q.cnt != '0)
    begin
      st_d.cnt = st_q.cnt - `ASR_TMR_W'(1);
    end
  end

  // Register the timer state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // Interval expired
  assign tmr.done = (st_q.cnt == '0);

endmodule : asr_timer

// >>> design/asr_host.sv
// Host controller that runs read and write cycles on an asynchronous SRAM
//
// Overview of operation
// - Sample only after full access time elapses
// - Address changes only with WE or select inactive
// - Address stable before the last starting edge
// - Drive write data only after device outputs off
// - Data stable setup before, hold after end
`timescale 1ns/1ns
`include "asr_map.svh"
module asr_host
#(
  parameter int ACC_CYC = `ASR_ACC_CYC,  // Read access cycles
  parameter int WP_CYC  = `ASR_WP_CYC    // Write pulse cycles
)
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   req_valid,
  input  wire logic                   req_write,
  input  wire logic [`ASR_ADDR_W-1:0] req_addr,
  input  wire logic [`ASR_DATA_W-1:0] req_wdata,
  input  wire logic [1:0]             req_be,
  output logic                        req_ready,
  output logic                        rd_valid,
  output logic [`ASR_DATA_W-1:0]      rd_data,
  output logic                        wr_done,
  output logic [`ASR_ADDR_W-1:0]      sram_addr,
  output logic                        sram_select_low_active,
  output logic                        sram_select_high_active,
  output logic                        sram_output_enable_n,
  output logic                        sram_write_enable_n,
  output logic                        upper_byte_enable_n,
  output logic                        lower_byte_enable_n,
  input  wire logic [`ASR_DATA_W-1:0] sram_dq_in,
  output logic [`ASR_DATA_W-1:0]      sram_dq_out,
  output logic                        sram_dq_oe
);

  // Read wait covers access time plus the synchroniser delay
  localparam int RD_CYC = ACC_CYC + `ASR_SYNC_CYC;

  asr_pkg::asr_state_t st_q;  // Registered sequencer state
  asr_pkg::asr_state_t st_d;  // Next sequencer state
  asr_tmr_if           tmr(); // Timer carrier

  // Interval length minus one, sized for the timer
  function automatic logic [`ASR_TMR_W-1:0] tmr_len(input int cyc);
    tmr_len = `ASR_TMR_W'(cyc - 1);
  endfunction : tmr_len

  // Phase timer
  asr_timer u_timer
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tmr      (tmr.tmr)
  );

  // Sequencer next state and pin values
  always_comb
  begin
    st_d          = st_q;
    st_d.rd_valid = 1'b0;
    st_d.wr_done  = 1'b0;
    tmr.load      = 1'b0;
    tmr.load_val  = '0;
    // Two-stage synchroniser on the data pins
    st_d.dq_s1    = sram_dq_in;
    st_d.dq_s2    = st_q.dq_s1;
    case (st_q.fsm)
      asr_pkg::ASR_IDLE:
      begin
        // Address moves only while deselected with WE high
        if (req_valid)
        begin
          st_d.addr   = req_addr;
          st_d.sel_lo = 1'b0;
          st_d.sel_hi = 1'b1;
          st_d.ube_n  = ~req_be[1];
          st_d.lbe_n  = ~req_be[0];
          st_d.ready  = 1'b0;
          tmr.load    = 1'b1;
          if (req_write)
          begin
            // Outputs stay off (OE high), so driving data is safe
            st_d.dq_out  = req_wdata;
            st_d.dq_oe   = 1'b1;
            st_d.fsm     = asr_pkg::ASR_W_SETUP;
            tmr.load_val = tmr_len(`ASR_AS_CYC);
          end
          else
          begin
            // Read: WE high, OE low with both selects active
            st_d.oe_n    = 1'b0;
            st_d.fsm     = asr_pkg::ASR_R_WAIT;
            tmr.load_val = tmr_len(RD_CYC);
          end
        end
      end
      asr_pkg::ASR_W_SETUP:
      begin
        // Address already stable; WE falling is the last start edge
        if (tmr.done)
        begin
          st_d.we_n    = 1'b0;
          st_d.fsm     = asr_pkg::ASR_W_PULSE;
          tmr.load     = 1'b1;
          tmr.load_val = tmr_len(WP_CYC);
        end
      end
      asr_pkg::ASR_W_PULSE:
      begin
        // WE rising terminates the write; data held through it
        if (tmr.done)
        begin
          st_d.we_n    = 1'b1;
          st_d.fsm     = asr_pkg::ASR_W_HOLD;
          tmr.load     = 1'b1;
          tmr.load_val = tmr_len(`ASR_DH_CYC);
        end
      end
      asr_pkg::ASR_W_HOLD:
      begin
        // Hold data after the end edge, then release and deselect
        if (tmr.done)
        begin
          st_d.dq_oe   = 1'b0;
          st_d.sel_lo  = 1'b1;
          st_d.sel_hi  = 1'b0;
          st_d.ube_n   = 1'b1;
          st_d.lbe_n   = 1'b1;
          st_d.wr_done = 1'b1;
          st_d.ready   = 1'b1;
          st_d.fsm     = asr_pkg::ASR_IDLE;
        end
      end
      asr_pkg::ASR_R_WAIT:
      begin
        // Capture only after full access time plus synchroniser
        if (tmr.done)
        begin
          st_d.rd_data  = st_q.dq_s2;
          st_d.rd_valid = 1'b1;
          st_d.oe_n     = 1'b1;
          st_d.sel_lo   = 1'b1;
          st_d.sel_hi   = 1'b0;
          st_d.ube_n    = 1'b1;
          st_d.lbe_n    = 1'b1;
          st_d.ready    = 1'b1;
          st_d.fsm      = asr_pkg::ASR_IDLE;
        end
      end
      default:
      begin
        st_d.fsm = asr_pkg::ASR_IDLE;
      end
    endcase
  end

  // Register the sequencer state; bus idles deselected
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q         <= '0;
      st_q.fsm     <= asr_pkg::ASR_IDLE;
      st_q.sel_lo  <= 1'b1;
      st_q.oe_n    <= 1'b1;
      st_q.we_n    <= 1'b1;
      st_q.ube_n   <= 1'b1;
      st_q.lbe_n   <= 1'b1;
      st_q.ready   <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flip-flops
  assign req_ready               = st_q.ready;
  assign rd_valid                = st_q.rd_valid;
  assign rd_data                 = st_q.rd_data;
  assign wr_done                 = st_q.wr_done;
  assign sram_addr               = st_q.addr;
  assign sram_select_low_active  = st_q.sel_lo;
  assign sram_select_high_active = st_q.sel_hi;
  assign sram_output_enable_n    = st_q.oe_n;
  assign sram_write_enable_n     = st_q.we_n;
  assign upper_byte_enable_n     = st_q.ube_n;
  assign lower_byte_enable_n     = st_q.lbe_n;
  assign sram_dq_out             = st_q.dq_out;
  assign sram_dq_oe              = st_q.dq_oe;

  // Cycles that output enable has been low, for the read check
  logic [7:0] oe_low_cnt_q;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      oe_low_cnt_q <= 8'h00;
    else if (st_q.oe_n)
      oe_low_cnt_q <= 8'h00;
    else if (oe_low_cnt_q != 8'hFF)
      oe_low_cnt_q <= oe_low_cnt_q + 8'h01;
  end

  // Write end edge and the data hold that must follow it
  sequence s_write_end;
    $rose(st_q.we_n);
  endsequence
  sequence s_data_held;
    st_q.dq_oe && $stable(st_q.dq_out);
  endsequence

  a_read_sample_wait:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(st_q.rd_valid) |-> oe_low_cnt_q >= 8'(RD_CYC))
    else $error("read sampled before access time");

  a_addr_move_safe:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      !$stable(st_q.addr) |-> st_q.we_n && $past(st_q.we_n)
        && $past(st_q.sel_lo))
    else $error("address changed during possible write");

  a_addr_before_we:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(st_q.we_n) |-> $stable(st_q.addr) && !st_q.sel_lo
        && st_q.sel_hi && $past(st_q.dq_oe))
    else $error("address not set up before write start");

  a_no_contention:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      st_q.dq_oe |-> st_q.oe_n && $past(st_q.oe_n))
    else $error("data driven while device outputs enabled");

  a_data_hold_end:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      s_write_end |-> s_data_held ##1 !st_q.dq_oe)
    else $error("write data not held after end edge");

endmodule : asr_host

// >>> test/asr_sram_model.sv
// Behavioural model of the asynchronous SRAM behind the host
`timescale 1ns/1ns
module asr_sram_model
#(
  parameter int T_ACC_NS = 120  // Read access time in ns
)
(
  input  wire logic [16:0] sram_addr,
  input  wire logic        sram_select_low_active,
  input  wire logic        sram_select_high_active,
  input  wire logic        sram_output_enable_n,
  input  wire logic        sram_write_enable_n,
  input  wire logic        upper_byte_enable_n,
  input  wire logic        lower_byte_enable_n,
  input  wire logic [15:0] dq_bus,
  output logic [15:0]      q,
  output logic             q_oe
);
  logic [15:0] mem [0:131071];  // Storage array
  time         t_last;          // Latest read starting event
  // Selected, not in standby
  wire sel = !sram_select_low_active && sram_select_high_active;
  // Write mode window
  wire wr_mode = sel && !sram_write_enable_n;
  // Read mode needs write off, output on and a byte lane
  wire rd_mode = sel && sram_write_enable_n && !sram_output_enable_n
    && !(upper_byte_enable_n && lower_byte_enable_n);
  // Access restarts on any address or mode change
  always @(sram_addr or rd_mode)
  begin
    t_last = $time;
  end
  // Outputs off the clock edges; garbage until access time runs out
  initial
  begin
    q = 16'h5A5A;
    q_oe = 1'b0;
    #3;
    forever
    begin
      q_oe = rd_mode;
      q = ~q;
      if (rd_mode && ($time - t_last >= T_ACC_NS))
      begin
        if (!upper_byte_enable_n)
          q[15:8] = mem[sram_addr][15:8];
        if (!lower_byte_enable_n)
          q[7:0] = mem[sram_addr][7:0];
      end
      #10;
    end
  end
  // Word lands at the first terminating edge
  always @(negedge wr_mode)
  begin
    if (!upper_byte_enable_n)
      mem[sram_addr][15:8] = dq_bus[15:8];
    if (!lower_byte_enable_n)
      mem[sram_addr][7:0] = dq_bus[7:0];
  end
endmodule : asr_sram_model

// >>> test/asr_host_tb.sv
// Self-checking testbench of the asynchronous SRAM host
`timescale 1ns/1ns
`include "asr_map.svh"
module asr_host_tb;
  typedef struct packed
  {
    logic w; logic [16:0] a; logic [15:0] d; logic [1:0] be;
    logic [15:0] exp; logic [31:0] t;
  } asr_tb_req_t;
  logic core_clk, rst_n, req_valid, req_write, req_ready, rd_valid, wr_done;
  logic [16:0] req_addr, sram_addr, a_p;
  logic [15:0] req_wdata, rd_data, sram_dq_out, q, dq_p, last_rd;
  logic [1:0]  req_be;
  logic sel_lo, sel_hi, oe_n, we_n, ube_n, lbe_n, sram_dq_oe, q_oe;
  logic we_p, oe_p, doe_p, rdy_s;
  logic [15:0] ref_m [int];       // Expected memory contents
  asr_tb_req_t pend[$], busy[$];  // Waiting and in-flight requests
  asr_tb_req_t e, m;
  int cyc, mismatches, n_tests;
  // Host drives the lines while enabled, else the device side
  wire [15:0] dq = sram_dq_oe ? sram_dq_out : q;
  asr_host dut (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_be(req_be), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .wr_done(wr_done), .sram_addr(sram_addr),
    .sram_select_low_active(sel_lo), .sram_select_high_active(sel_hi),
    .sram_output_enable_n(oe_n), .sram_write_enable_n(we_n),
    .upper_byte_enable_n(ube_n), .lower_byte_enable_n(lbe_n),
    .sram_dq_in(dq), .sram_dq_out(sram_dq_out), .sram_dq_oe(sram_dq_oe));
  asr_sram_model sram (.sram_addr(sram_addr), .sram_select_low_active(sel_lo),
    .sram_select_high_active(sel_hi), .sram_output_enable_n(oe_n),
    .sram_write_enable_n(we_n), .upper_byte_enable_n(ube_n),
    .lower_byte_enable_n(lbe_n), .dq_bus(dq), .q(q), .q_oe(q_oe));
  // Clock at 10 MHz
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Verdict and end of run
  task end_sim;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  // Queue one request
  task push(input logic w, input logic [16:0] a, input logic [15:0] d,
            input logic [1:0] be);
    pend.push_back('{w, a, d, be, 16'h0000, 32'h0});
  endtask : push
  // Wait until every queued request has answered
  task drain;
    int n;
    n = 0;
    while ((pend.size() > 0 || busy.size() > 0) && n < 100)
    begin
      @(negedge core_clk);
      n++;
    end
    check(n < 100, 1);
  endtask : drain
  // Request driver: holds the next request until it is taken
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (req_valid && rdy_s)
    begin
      e = pend.pop_front();
      e.t = cyc;
      if (e.w && e.be[1]) ref_m[e.a][15:8] = e.d[15:8];
      if (e.w && e.be[0]) ref_m[e.a][7:0] = e.d[7:0];
      if (!e.w) e.exp = ref_m[e.a];
      busy.push_back(e);
    end
    req_valid <= (pend.size() > 0);
    if (pend.size() > 0)
    begin
      req_write <= pend[0].w;
      req_addr  <= pend[0].a;
      req_wdata <= pend[0].d;
      req_be    <= pend[0].be;
    end
    // Ceiling on the run, far above what twenty requests need
    if (cyc > 3000)
    begin
      mismatches++;
      end_sim;
    end
  end
  // Answer and pin monitor at the settled half of each cycle
  always @(negedge core_clk)
  begin
    rdy_s = req_ready;
    if (rd_valid || wr_done)
    begin
      m = busy.pop_front();
      check(wr_done, m.w);
      check(cyc - m.t, m.w ? (`ASR_AS_CYC + `ASR_WP_CYC + `ASR_DH_CYC)
            : (`ASR_ACC_CYC + `ASR_SYNC_CYC));
      if (rd_valid)
        check(rd_data & {{8{m.be[1]}}, {8{m.be[0]}}},
              m.exp & {{8{m.be[1]}}, {8{m.be[0]}}});
      if (rd_valid) last_rd = rd_data;
      else check(rd_data, last_rd);
    end
    if (rst_n && sram_addr !== a_p) check(we_p && we_n, 1);
    if (rst_n && !(we_p && we_n))
      check({sram_dq_out, sram_dq_oe}, {dq_p, 1'b1});
    if (sram_dq_oe && !doe_p) check(oe_p && oe_n, 1);
    check(sram_dq_oe && q_oe, 0);
    {a_p, dq_p, we_p, oe_p, doe_p} = {sram_addr, sram_dq_out, we_n, oe_n,
                                      sram_dq_oe};
  end
  // Idle pins after reset leave the device in standby
  task t_reset;
    check({req_ready, sel_lo, sel_hi, oe_n, we_n, ube_n, lbe_n, sram_dq_oe},
          8'hDE);
  endtask : t_reset
  // Full words at both address ends, back to back
  task t_words;
    push(1, 17'h00000, 16'h1234, 2'h3);
    push(1, 17'h1FFFF, 16'hBEEF, 2'h3);
    push(1, 17'h0AAAA, 16'hC3A5, 2'h3);
    push(0, 17'h00000, 16'h0000, 2'h3);
    push(0, 17'h1FFFF, 16'h0000, 2'h3);
    push(0, 17'h0AAAA, 16'h0000, 2'h3);
    drain;
  endtask : t_words
  // Single byte lanes on write and read
  task t_lanes;
    push(1, 17'h00010, 16'h1122, 2'h3);
    push(1, 17'h00010, 16'hABCD, 2'h2);
    push(1, 17'h00010, 16'h5566, 2'h1);
    push(0, 17'h00010, 16'h0000, 2'h3);
    push(0, 17'h00010, 16'h0000, 2'h1);
    push(0, 17'h00010, 16'h0000, 2'h2);
    drain;
  endtask : t_lanes
  // Alternating write and read of the same word
  task t_mixed;
    for (int i = 0; i < 4; i++)
    begin
      push(1, 17'h00100 + 17'(i), 16'h0F0F ^ 16'(i * 16'h1111), 2'h3);
      push(0, 17'h00100 + 17'(i), 16'h0000, 2'h3);
    end
    drain;
  endtask : t_mixed
  // Main sequence
  initial
  begin
    {req_valid, req_write, req_addr, req_wdata, req_be} = '0;
    {cyc, mismatches, n_tests, rdy_s, last_rd} = '0;
    {a_p, dq_p, we_p, oe_p, doe_p} = {33'h0, 3'h6};
    rst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    t_reset;
    t_words;
    t_lanes;
    t_mixed;
    end_sim;
  end
endmodule : asr_host_tb
